// [src/psc_pkg.sv]
// Package of constants and types for the strap configuration and enable block.
package psc_pkg;

    // ------------------------------------------------------------------
    // Command codes for read-back and control
    // ------------------------------------------------------------------
    localparam logic [7:0] PSC_CMD_OPERATION  = 8'h01; // Operation command.
    localparam logic [7:0] PSC_CMD_ON_OFF_CFG = 8'h02; // On/off config.
    localparam logic [7:0] PSC_CMD_BOOT_CODE  = 8'hDC; // Boot strap code.
    localparam logic [7:0] PSC_CMD_MODE_CODE  = 8'hDD; // Mode strap code.
    localparam logic [7:0] PSC_CMD_FAULT_CODE = 8'hDE; // Fault strap code.
    localparam logic [7:0] PSC_CMD_RAMP_CODE  = 8'hDF; // Ramp strap code.

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PSC_OP_ON_BIT      = 7;  // Operation on bit.
    localparam int PSC_CFG_PIN_BIT    = 1;  // Pin is honoured.
    localparam int PSC_CFG_CMD_BIT    = 0;  // Command is honoured.
    localparam int PSC_PFM_BIT        = 7;  // Mode strap: forced PWM.
    localparam int PSC_TCOMP_HI       = 6;  // Mode strap: temp comp.
    localparam int PSC_TCOMP_LO       = 5;
    localparam int PSC_ADDR_HI        = 4;  // Mode strap: address.
    localparam int PSC_ULTRA_BIT      = 7;  // Fault strap: ultrasonic.
    localparam int PSC_FAULT_BIT      = 6;  // Fault strap: retry policy.
    localparam int PSC_FSW_HI         = 5;
    localparam int PSC_FSW_LO         = 3;
    localparam int PSC_GAIN_HI        = 2;
    localparam int PSC_RAMP_HI        = 7;  // Ramp strap fields.
    localparam int PSC_RAMP_LO        = 5;
    localparam int PSC_RR_HI          = 4;
    localparam int PSC_RR_LO          = 3;
    localparam int PSC_MULT_BIT       = 2;

    // ------------------------------------------------------------------
    // Reset values and address base
    // ------------------------------------------------------------------
    localparam logic [7:0] PSC_OP_RESET   = 8'h00; // Operation: off.
    localparam logic [7:0] PSC_CFG_RESET  = 8'h02; // Pin only.
    localparam logic [6:0] PSC_ADDR_BASE  = 7'h60; // Address for code 0.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PSC_CLK_MHZ        = 100;  // Clock rate in MHz.
    localparam int PSC_TIMEOUT_US     = 5500; // Typical start timeout.
    localparam int PSC_TIMEOUT_MAX_US = 6500; // Worst-case timeout.
    localparam int PSC_TIMEOUT_CYC    = PSC_TIMEOUT_US * PSC_CLK_MHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_ST_OFF   = 2'b00, // Bias rails not yet up.
        PSC_ST_SAMP  = 2'b01, // Capturing strap codes.
        PSC_ST_WAIT  = 2'b10, // Start-up timeout running.
        PSC_ST_READY = 2'b11  // Power good, enable gating live.
    } psc_state_t;

    // Decoded configuration driven toward the regulator.
    typedef struct packed {
        logic [7:0] boot_code;     // Boot voltage code.
        logic       forced_pwm;    // 1 forces PWM, 0 allows light load.
        logic [1:0] temp_comp;     // Temperature compensation select.
        logic [6:0] bus_address;   // Seven-bit serial bus address.
        logic       ultrasonic;    // Ultrasonic light load enable.
        logic       fault_retry;   // 1 selects retry, 0 latch off.
        logic [2:0] freq_sel;      // Switching frequency select.
        logic [2:0] gain_sel;      // Error amplifier gain select.
        logic [2:0] ramp_sel;      // Ramp rate select.
        logic [1:0] ripple_sel;    // Ripple resistance select.
        logic       gain_mult;     // Gain multiplier, 1 means 2x.
    } psc_cfg_t;

    // Bias and enable levels that gate the controller.
    typedef struct packed {
        logic high_bias_rail;      // High bias rail above threshold.
        logic driver_bias_rail;    // Driver bias rail above threshold.
        logic vcc_rail;            // Logic bias above threshold.
        logic vin_rail;            // Input rail above threshold.
        logic enable_pin;          // Enable pin above threshold.
    } psc_bias_t;

endpackage

// [src/psc_sync.sv]
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
module psc_sync
    import psc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    logic [W-1:0] meta_reg;   // First stage, read only by the second.

    // Both stages clear to zero so everything reads as "below threshold".
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [src/psc_top.sv]
// Strap sampling, decoding, command read-back and enable gating.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [R01] Enable only after all rails, pin, timeout.
// [R02] Drop enable when any rail or pin falls.
// [R03] On/off config picks command, pin or both; the pin is always required.
// [R04] Boot strap gives full 8-bit voltage code.
// [R05] Mode bit 7 clear allows light load.
// [R06] Mode bits 6:5 pick temperature compensation.
// [R07] Mode bits 4:0 pick bus address.
// [R08] Fault strap bit 7 enables ultrasonic mode.
// [R09] Fault strap bit 6 picks latch or retry.
// [R10] Fault strap bits pick frequency and gain.
// [R11] Ramp strap bits 7:5 pick ramp rate.
// [R12] Ramp strap bits 4:3 pick ripple resistance.
// [R13] Bit 2 picks multiplier; bits 1:0 ignored.
// [R14] Commands DC to DF read strap codes.
// [R15] Boot code passes through unaltered for mapping.
// [R16] Address code zero is 60h, all ones 7Fh.
// [R17] Sample straps once after power-up, hold.
module psc_top
    import psc_pkg::*;
#(
    parameter int TIMEOUT_CYC = PSC_TIMEOUT_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire psc_bias_t  bias_in,
    input  wire logic [7:0] boot_voltage_strap,
    input  wire logic [7:0] mode_address_strap,
    input  wire logic [7:0] fault_freq_strap,
    input  wire logic [7:0] ramp_gain_strap,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_wdata,
    output logic      [7:0] cmd_rdata,
    output logic            cmd_rvalid,
    output logic            cmd_err,
    output psc_cfg_t        cfg_out,
    output logic            cfg_valid,
    output logic            ctrl_enable
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int SW = 5 + 32;             // Bias levels and four codes.

    logic [SW-1:0] sync_vec;                // Synchronised inputs.
    psc_bias_t     bias_s;                  // Synchronised bias levels.
    logic [7:0]    boot_s;                  // Synchronised boot strap.
    logic [7:0]    mode_s;                  // Synchronised mode strap.
    logic [7:0]    fault_s;                 // Synchronised fault strap.
    logic [7:0]    ramp_s;                  // Synchronised ramp strap.

    // Strap codes come from a slow converter outside this clock, so they
    // are synchronised with the rails; they are quiet while sampled.
    psc_sync #(.W(SW)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({bias_in, boot_voltage_strap, mode_address_strap,
                    fault_freq_strap, ramp_gain_strap}),
        .sync_out (sync_vec)
    );

    assign bias_s  = psc_bias_t'(sync_vec[SW-1:32]);
    assign boot_s  = sync_vec[31:24];
    assign mode_s  = sync_vec[23:16];
    assign fault_s = sync_vec[15:8];
    assign ramp_s  = sync_vec[7:0];

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    psc_state_t  state_reg, state_next;     // Power-up sequencer.
    logic [31:0] tmo_reg, tmo_next;         // Start-up timeout counter.
    logic [7:0]  boot_reg;                  // Held boot strap code.
    logic [7:0]  mode_reg;                  // Held mode strap code.
    logic [7:0]  fault_reg;                 // Held fault strap code.
    logic [7:0]  ramp_reg;                  // Held ramp strap code.
    logic [7:0]  op_reg;                    // Operation command value.
    logic [7:0]  cfg_reg;                   // On/off configuration.

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Maps the five-bit strap field onto the bus address space.
    function automatic logic [6:0] addr_map(input logic [4:0] code);
        addr_map = PSC_ADDR_BASE | {2'b00, code}; // [R16]
    endfunction

    // Answers a read command, flagging codes that are not mapped.
    function automatic logic [8:0] rd_mux(input logic [7:0] code,
                                          input logic [7:0] b,
                                          input logic [7:0] m,
                                          input logic [7:0] f,
                                          input logic [7:0] r,
                                          input logic [7:0] o,
                                          input logic [7:0] c);
        case (code)
            PSC_CMD_BOOT_CODE:  rd_mux = {1'b0, b}; // [R14]
            PSC_CMD_MODE_CODE:  rd_mux = {1'b0, m}; // [R14]
            PSC_CMD_FAULT_CODE: rd_mux = {1'b0, f}; // [R14]
            PSC_CMD_RAMP_CODE:  rd_mux = {1'b0, r}; // [R14]
            PSC_CMD_OPERATION:  rd_mux = {1'b0, o};
            PSC_CMD_ON_OFF_CFG: rd_mux = {1'b0, c};
            default:            rd_mux = {1'b1, 8'h00};
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Combinational conditions
    // ------------------------------------------------------------------
    wire bias_ok  = bias_s.high_bias_rail & bias_s.driver_bias_rail
                  & bias_s.vcc_rail & bias_s.vin_rail;
    wire all_up   = bias_ok & bias_s.enable_pin;        // [R01]
    wire tmo_done = (tmo_reg == 32'(TIMEOUT_CYC - 1));
    // Enable request depends on which sources the config honours.
    wire pin_ok   = ~cfg_reg[PSC_CFG_PIN_BIT] | bias_s.enable_pin;
    wire cmd_ok   = ~cfg_reg[PSC_CFG_CMD_BIT] | op_reg[PSC_OP_ON_BIT];
    wire req_on   = pin_ok & cmd_ok;                    // [R03]
    wire [8:0] rd_word = rd_mux(cmd_code, boot_reg, mode_reg, fault_reg,
                                ramp_reg, op_reg, cfg_reg);
    wire wr_op    = cmd_wr & (cmd_code == PSC_CMD_OPERATION);
    wire wr_cfg   = cmd_wr & (cmd_code == PSC_CMD_ON_OFF_CFG);

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // Bias loss from any state returns to off and clears the timer; the
    // pin always restarts the timeout, whatever the on/off config says.
    always_comb begin
        state_next = state_reg;
        tmo_next   = tmo_reg;
        case (state_reg)
            PSC_ST_OFF: begin
                tmo_next = '0;
                if (bias_ok) begin
                    state_next = PSC_ST_SAMP;
                end
            end
            PSC_ST_SAMP: begin
                state_next = bias_ok ? PSC_ST_WAIT : PSC_ST_OFF;
            end
            PSC_ST_WAIT: begin
                if (!all_up) begin
                    tmo_next = '0;                      // [R01]
                    if (!bias_ok) begin
                        state_next = PSC_ST_OFF;
                    end
                end else if (tmo_done) begin
                    state_next = PSC_ST_READY;          // [R01]
                end else begin
                    tmo_next = tmo_reg + 32'd1;
                end
            end
            PSC_ST_READY: begin
                if (!bias_ok) begin
                    state_next = PSC_ST_OFF;            // [R02]
                end else if (!bias_s.enable_pin) begin
                    state_next = PSC_ST_WAIT;           // [R02]
                    tmo_next   = '0;
                end
            end
            default: begin
                state_next = PSC_ST_OFF;
                tmo_next   = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg <= PSC_ST_OFF;
            tmo_reg   <= '0;
        end else begin
            state_reg <= state_next;
            tmo_reg   <= tmo_next;
        end
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Codes are taken once per power-up; later strap motion is ignored
    // so the regulator never sees its setup change while running.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            boot_reg  <= 8'h00;
            mode_reg  <= 8'h00;
            fault_reg <= 8'h00;
            ramp_reg  <= 8'h00;
        end else if (state_reg == PSC_ST_SAMP) begin
            boot_reg  <= boot_s;                        // [R17]
            mode_reg  <= mode_s;                        // [R17]
            fault_reg <= fault_s;                       // [R17]
            ramp_reg  <= ramp_s;                        // [R17]
        end
    end

    // ------------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------------
    // Strap codes are read-only; writes to them are refused with error.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            op_reg  <= PSC_OP_RESET;
            cfg_reg <= PSC_CFG_RESET;
        end else begin
            if (wr_op) begin
                op_reg <= cmd_wdata;                    // [R03]
            end
            if (wr_cfg) begin
                cfg_reg <= cmd_wdata;                   // [R03]
            end
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cmd_rdata  <= 8'h00;
            cmd_rvalid <= 1'b0;
            cmd_err    <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_rd;
            cmd_rdata  <= cmd_rd ? rd_word[7:0] : 8'h00; // [R14]
            cmd_err    <= (cmd_rd & rd_word[8])
                        | (cmd_wr & ~wr_op & ~wr_cfg);
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration and enable output
    // ------------------------------------------------------------------
    // Enable drops in the same edge the sequencer leaves ready, so a
    // falling rail disables within the synchroniser delay plus one.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg_out     <= '0;
            cfg_valid   <= 1'b0;
            ctrl_enable <= 1'b0;
        end else begin
            cfg_valid   <= (state_reg == PSC_ST_WAIT)
                         | (state_reg == PSC_ST_READY);
            ctrl_enable <= (state_next == PSC_ST_READY) & req_on; // [R01]
            cfg_out.boot_code   <= boot_reg;                    // [R04] [R15]
            cfg_out.forced_pwm  <= mode_reg[PSC_PFM_BIT];       // [R05]
            cfg_out.temp_comp   <= mode_reg[PSC_TCOMP_HI:PSC_TCOMP_LO]; // [R06]
            cfg_out.bus_address <= addr_map(mode_reg[PSC_ADDR_HI:0]); // [R07]
            cfg_out.ultrasonic  <= fault_reg[PSC_ULTRA_BIT];    // [R08]
            cfg_out.fault_retry <= ~fault_reg[PSC_FAULT_BIT];   // [R09]
            cfg_out.freq_sel    <= fault_reg[PSC_FSW_HI:PSC_FSW_LO]; // [R10]
            cfg_out.gain_sel    <= fault_reg[PSC_GAIN_HI:0];    // [R10]
            cfg_out.ramp_sel    <= ramp_reg[PSC_RAMP_HI:PSC_RAMP_LO]; // [R11]
            cfg_out.ripple_sel  <= ramp_reg[PSC_RR_HI:PSC_RR_LO]; // [R12]
            cfg_out.gain_mult   <= ramp_reg[PSC_MULT_BIT];      // [R13]
        end
    end

endmodule
`default_nettype wire

// [dv/psc_top_assertions.sv]
// Concurrent checks on the ports of the strap configuration block.
`timescale 1ns/100ps
`default_nettype none
module psc_top_checker
    import psc_pkg::*;
#(
    parameter int TIMEOUT_CYC = PSC_TIMEOUT_CYC
) (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire psc_bias_t  bias_in,
    input wire logic       cmd_wr,
    input wire logic       cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_rdata,
    input wire logic       cmd_rvalid,
    input wire logic       cmd_err,
    input wire psc_cfg_t   cfg_out,
    input wire logic       cfg_valid,
    input wire logic       ctrl_enable
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [19:0] up_cnt_reg; // Unbroken cycles with every rail and the pin up.

    // Saturates so a long powered run never wraps back to a small count.
    always_ff @(posedge ref_clk) begin
        if (!resetn || !(&bias_in)) begin
            up_cnt_reg <= 20'h00000;
        end else if (up_cnt_reg != 20'hFFFFF) begin
            up_cnt_reg <= up_cnt_reg + 20'h00001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    enable_timeout_a: assert property (
        $rose(ctrl_enable) |-> up_cnt_reg >= TIMEOUT_CYC)
        else $error("enable rose before the start-up timeout");
    enable_valid_a: assert property (ctrl_enable |-> cfg_valid)
        else $error("enable high without captured straps");
    rail_drop_a: assert property ($fell(&bias_in) |-> ##[1:4] !ctrl_enable)
        else $error("enable stayed high after a rail or pin fell");
    write_refuse_a: assert property (
        cmd_wr && !(cmd_code inside {8'h01, 8'h02}) |=> cmd_err)
        else $error("write to a read-only or unknown code not refused");
    code_read_a: assert property (
        cmd_rd && cmd_code inside {[8'hDC:8'hDF]} |=> cmd_rvalid && !cmd_err)
        else $error("strap code read not answered");
    unmapped_read_a: assert property (
        cmd_rd && !(cmd_code inside {[8'hDC:8'hDF], 8'h01, 8'h02})
        |=> cmd_err && cmd_rdata == 8'h00)
        else $error("unmapped read not refused");
    cfg_hold_a: assert property (
        cfg_valid && $past(cfg_valid) |-> $stable(cfg_out))
        else $error("captured configuration changed while held");
    addr_base_a: assert property (
        cfg_valid |-> cfg_out.bus_address[6:5] == 2'b11)
        else $error("bus address outside the 60h to 7Fh range");
    boot_read_a: assert property (
        cmd_rd && cmd_code == PSC_CMD_BOOT_CODE && cfg_valid
        |=> cmd_rdata == $past(cfg_out.boot_code))
        else $error("boot code read-back differs from decoded code");
    mode_read_a: assert property (
        cmd_rd && cmd_code == PSC_CMD_MODE_CODE && cfg_valid
        |=> cmd_rdata == $past({cfg_out.forced_pwm, cfg_out.temp_comp,
                                cfg_out.bus_address[4:0]}))
        else $error("mode fields disagree with mode code");
    fault_read_a: assert property (
        cmd_rd && cmd_code == PSC_CMD_FAULT_CODE && cfg_valid
        |=> cmd_rdata == $past({cfg_out.ultrasonic, !cfg_out.fault_retry,
                                cfg_out.freq_sel, cfg_out.gain_sel}))
        else $error("fault fields disagree with fault code");
    ramp_read_a: assert property (
        cmd_rd && cmd_code == PSC_CMD_RAMP_CODE && cfg_valid
        |=> cmd_rdata[7:2] == $past({cfg_out.ramp_sel, cfg_out.ripple_sel,
                                     cfg_out.gain_mult}))
        else $error("ramp fields disagree with ramp code");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    cover property ($rose(ctrl_enable));
    cover property ($fell(ctrl_enable));
    cover property (cmd_err);
endmodule
`default_nettype wire

// [dv/psc_rail_model.sv]
// Bias supply and strap divider model facing the configuration block.
`timescale 1ns/100ps
`default_nettype none
module psc_rail_model
    import psc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        power_on,
    input  wire logic        pin_on,
    input  wire logic [31:0] strap_set,
    output psc_bias_t        bias,
    output logic      [31:0] strap_pins
);
    logic [3:0] rail_reg; // One bit per rail, raised one cycle apart.

    // Rails build up in turn but collapse together, the harsh case.
    always_ff @(posedge ref_clk) begin
        if (!power_on) begin
            rail_reg <= 4'h0;
        end else begin
            rail_reg <= {rail_reg[2:0], 1'b1};
        end
    end

    assign bias = {rail_reg[2], rail_reg[1], rail_reg[3], rail_reg[0],
                   pin_on};
    // Dividers refer to the logic bias; without it the level is garbage.
    assign strap_pins = rail_reg[3] ? strap_set : ~strap_set;
endmodule
`default_nettype wire

// [dv/psc_top_tb.sv]
// Self-checking testbench for the strap configuration block.
`timescale 1ns/100ps
`default_nettype none
module psc_top_tb;
    import psc_pkg::*;
    localparam int TIMEOUT_CYC = 20;   // Shortened start-up timeout.
    localparam int LIMIT       = 5000; // Cycle ceiling for a hung run.
    logic        ref_clk, resetn, power_on, pin_on, cmd_wr, cmd_rd;
    logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, rd;
    logic [31:0] strap_set, strap_pins, s;
    logic        cmd_rvalid, cmd_err, cfg_valid, ctrl_enable, er;
    psc_bias_t   bias;
    psc_cfg_t    cfg_out;
    int          failures, n_tests, cyc, n;
    logic [31:0] corners [5] = '{32'h80001F00, 32'hDF1FFF1F, 32'hFFE040FF,
                                 32'h0, 32'h0};

    psc_rail_model u_psc_rail_model (.ref_clk(ref_clk), .power_on(power_on),
        .pin_on(pin_on), .strap_set(strap_set), .bias(bias),
        .strap_pins(strap_pins));
    psc_top #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_psc_top (.ref_clk(ref_clk),
        .resetn(resetn), .bias_in(bias),
        .boot_voltage_strap(strap_pins[31:24]),
        .mode_address_strap(strap_pins[23:16]),
        .fault_freq_strap(strap_pins[15:8]),
        .ramp_gain_strap(strap_pins[7:0]), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err), .cfg_out(cfg_out),
        .cfg_valid(cfg_valid), .ctrl_enable(ctrl_enable));

    // Expected decode of the four strap bytes packed boot first.
    function automatic psc_cfg_t exp_cfg(input logic [31:0] v);
        psc_cfg_t c;
        c.boot_code   = v[31:24];
        c.forced_pwm  = v[23];
        c.temp_comp   = v[22:21];
        c.bus_address = {2'b11, v[20:16]};
        c.ultrasonic  = v[15];
        c.fault_retry = !v[14];
        c.freq_sel    = v[13:11];
        c.gain_sel    = v[10:8];
        c.ramp_sel    = v[7:5];
        c.ripple_sel  = v[4:3];
        c.gain_mult   = v[2];
        return c;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One command held for one edge; answer taken just after that same edge.
    task automatic cmd(input logic wr, input logic [7:0] code, dat);
        @(posedge ref_clk);
        cmd_wr    <= wr;
        cmd_rd    <= !wr;
        cmd_code  <= code;
        cmd_wdata <= dat;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        #1;
        rd = cmd_rdata;
        er = cmd_err;
    endtask

    // Waits, with a bound, for the enable to reach a level.
    task automatic wait_en(input logic v);
        n = 0;
        while (ctrl_enable !== v && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons: %0d  mismatches: %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // A hang is cut short and judged as a mismatch.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        {resetn, power_on, pin_on, cmd_wr, cmd_rd} = 5'h00;
        {cmd_code, cmd_wdata, strap_set} = 48'h0;
        {failures, n_tests, cyc} = '0;
        void'($urandom(45401));
        corners[3] = $urandom();
        corners[4] = $urandom();
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        // Each power cycle: capture, decode, read back, hold, drop.
        for (int i = 0; i < 5; i++) begin
            s = corners[i];
            @(posedge ref_clk);
            strap_set <= s;
            power_on  <= 1'b1;
            pin_on    <= 1'b1;
            wait_en(1'b1);
            check(n > TIMEOUT_CYC && n <= TIMEOUT_CYC + 12, 1);
            check(cfg_out, exp_cfg(s));
            check(cfg_out, exp_cfg(s));
            for (int k = 0; k < 4; k++) begin
                cmd(1'b0, 8'hDC + 8'(k), 8'h00);
                check(rd, 32'(s >> (24 - 8 * k)) & 32'hFF);
            end
            strap_set <= ~s;
            repeat (5) @(posedge ref_clk);
            check(cfg_out, exp_cfg(s));
            if (i == 0) begin
                // Pin loss drops the enable; restore re-runs the timeout.
                pin_on <= 1'b0;
                wait_en(1'b0);
                check(n <= 6, 1);
                pin_on <= 1'b1;
                wait_en(1'b1);
                check(n >= TIMEOUT_CYC && n <= TIMEOUT_CYC + 12, 1);
                // Strap writes and unknown reads are refused.
                cmd(1'b1, PSC_CMD_BOOT_CODE, ~s[31:24]);
                check(er, 1);
                cmd(1'b0, PSC_CMD_BOOT_CODE, 8'h00);
                check(rd, s[31:24]);
                cmd(1'b0, 8'h55, 8'h00);
                check({er, rd}, 9'h100);
            end
            power_on <= 1'b0;
            wait_en(1'b0);
            check(n <= 8, 1);
        end
        // Every on/off setting against both operation states.
        power_on <= 1'b1;
        wait_en(1'b1);
        for (int c = 0; c < 8; c++) begin
            cmd(1'b1, PSC_CMD_ON_OFF_CFG, 8'(c >> 1));
            cmd(1'b1, PSC_CMD_OPERATION, {c[0], 7'($urandom())});
            cmd(1'b0, 8'h02, 8'h00);
            check(rd, 8'(c >> 1));
            repeat (3) @(posedge ref_clk);
            check(ctrl_enable, !c[1] | c[0]);
        end
        print_verdict();
    end
endmodule

bind psc_top psc_top_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_psc_top_checker (
    .ref_clk(ref_clk), .resetn(resetn), .bias_in(bias_in), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err), .cfg_out(cfg_out),
    .cfg_valid(cfg_valid), .ctrl_enable(ctrl_enable));
`default_nettype wire
